// File: lbc_pkg.sv
// Constants, code table and helpers for the in-band and data link loopback controller.
// Assumes one 20 MHz clock; all line-side strobes come from mclk logic.
package lbc_pkg;

   // Clock and timing
   localparam int CLK_HZ     = 20_000_000;
   localparam int TICK_S     = 1;
   localparam int SEC_CYCLES = CLK_HZ * TICK_S;
   localparam int QUAL_S     = 5;
   localparam int AIS_S      = 2;
   localparam int LOOPED_S   = 5;
   localparam int REPEAT_S   = 20;
   localparam int SECS_W     = 5;

   // Detector sizing
   localparam int PAT_W      = 16;
   localparam int BITS_W     = 22;
   localparam int MISS_SHIFT = 3;

   // Burst sizes per unit
   localparam logic [7:0] ERR_CENTRAL = 8'he7;
   localparam logic [7:0] ERR_REP1    = 8'h0a;
   localparam logic [7:0] ERR_REP2    = 8'hc8;
   localparam logic [7:0] ERR_REP3    = 8'h1e;
   localparam logic [7:0] ERR_REMOTE  = 8'h14;

   typedef enum logic [2:0] {
      ROLE_CENTRAL, ROLE_REP1, ROLE_REP2, ROLE_REP3, ROLE_REMOTE
   } lbc_role_type;

   typedef enum logic [1:0] {
      SRC_NET_IB, SRC_CUST_IB, SRC_NET_DL, SRC_CUST_DL
   } lbc_src_type;

   typedef enum logic [3:0] {
      CMD_ARM_NET, CMD_ARM_CUST, CMD_DISARM, CMD_LOOP_NET, CMD_LOOP_CUST,
      CMD_ADDR_NET, CMD_ADDR_CUST, CMD_CONFIRM, CMD_LOOPDOWN, CMD_QUERY
   } lbc_cmd_type;

   // Code table, first transmitted bit at position LEN-1 for in-band codes, at bit 0 for data link codes
   localparam int NUM_CODES = 28;
   localparam logic [15:0] CODE_PAT [NUM_CODES] = '{
      16'h0018, 16'h001c, 16'h001c, 16'hff48, 16'hff48, 16'hff24, 16'hff24,
      16'h0070, 16'h0078, 16'h0030, 16'h0038, 16'h007e, 16'h007c, 16'h003c,
      16'h003e, 16'hff1e, 16'hff04, 16'hff06, 16'hff08, 16'hff02, 16'h3f1e,
      16'h3f04, 16'h3f06, 16'h3f08, 16'h3f02, 16'hd3d3, 16'h9393, 16'hd5d5};
   localparam int CODE_LEN [NUM_CODES] = '{
      5, 5, 5, 16, 16, 16, 16, 7, 7, 6, 6, 7, 7, 6,
      6, 16, 16, 16, 16, 16, 16, 16, 16, 16, 16, 16, 16, 16};
   localparam lbc_src_type CODE_SRC [NUM_CODES] = '{
      SRC_NET_IB, SRC_NET_IB, SRC_CUST_IB, SRC_NET_DL, SRC_CUST_DL,
      SRC_NET_DL, SRC_CUST_DL, SRC_NET_IB, SRC_NET_IB, SRC_NET_IB,
      SRC_NET_IB, SRC_CUST_IB, SRC_CUST_IB, SRC_CUST_IB, SRC_CUST_IB,
      SRC_NET_IB, SRC_NET_IB, SRC_NET_IB, SRC_NET_IB, SRC_NET_IB,
      SRC_CUST_IB, SRC_CUST_IB, SRC_CUST_IB, SRC_CUST_IB, SRC_CUST_IB,
      SRC_NET_IB, SRC_NET_IB, SRC_NET_IB};
   localparam lbc_cmd_type CODE_CMD [NUM_CODES] = '{
      CMD_ARM_NET, CMD_DISARM, CMD_DISARM, CMD_ARM_NET, CMD_ARM_CUST,
      CMD_DISARM, CMD_DISARM, CMD_LOOP_NET, CMD_LOOP_NET, CMD_LOOP_NET,
      CMD_LOOP_NET, CMD_LOOP_CUST, CMD_LOOP_CUST, CMD_LOOP_CUST,
      CMD_LOOP_CUST, CMD_ADDR_NET, CMD_ADDR_NET, CMD_ADDR_NET, CMD_ADDR_NET,
      CMD_ADDR_NET, CMD_ADDR_CUST, CMD_ADDR_CUST, CMD_ADDR_CUST,
      CMD_ADDR_CUST, CMD_ADDR_CUST, CMD_CONFIRM, CMD_LOOPDOWN, CMD_QUERY};
   localparam lbc_role_type CODE_ROLE [NUM_CODES] = '{
      ROLE_CENTRAL, ROLE_CENTRAL, ROLE_CENTRAL, ROLE_CENTRAL, ROLE_CENTRAL,
      ROLE_CENTRAL, ROLE_CENTRAL, ROLE_REMOTE, ROLE_CENTRAL, ROLE_REP1,
      ROLE_REP2, ROLE_CENTRAL, ROLE_REMOTE, ROLE_REP1, ROLE_REP2,
      ROLE_CENTRAL, ROLE_REP1, ROLE_REP2, ROLE_REP3, ROLE_REMOTE,
      ROLE_CENTRAL, ROLE_REP1, ROLE_REP2, ROLE_REP3, ROLE_REMOTE,
      ROLE_CENTRAL, ROLE_CENTRAL, ROLE_CENTRAL};

   // Bit reversal for data link words sent rightmost bit first
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++) r[i] = v[15 - i];
      return r;
   endfunction : rev16

   // True when history equals any rotation of the pattern
   function automatic logic rot_match(input logic [15:0] h,
                                      input logic [15:0] p,
                                      input int          len);
      logic hit;
      logic ok;
      int   j;
      hit = 1'b0;
      for (int r = 0; r < 16; r++) begin
         ok = (r < len);
         for (int i = 0; i < 16; i++) begin
            j = (i + r) % len;
            if (i < len && h[i] != p[j]) ok = 1'b0;
         end
         hit = hit | ok;
      end
      return hit;
   endfunction : rot_match

   // Error burst length for a unit
   function automatic logic [7:0] err_count(input lbc_role_type role);
      case (role)
         ROLE_CENTRAL: return ERR_CENTRAL;
         ROLE_REP1:    return ERR_REP1;
         ROLE_REP2:    return ERR_REP2;
         ROLE_REP3:    return ERR_REP3;
         default:      return ERR_REMOTE;
      endcase
   endfunction : err_count

endpackage : lbc_pkg

// File: lbc_bit_if.sv
// Serial bit stream between the controller and its code detectors.
// Assumes strobes are one mclk cycle wide.
`timescale 1ns/1ps
interface lbc_bit_if;
   logic bit_en;
   logic bit_val;
   logic frame;
   modport src (output bit_en, output bit_val, output frame);
   modport dst (input bit_en, input bit_val, input frame);
endinterface : lbc_bit_if

// File: lbc_code_det.sv
// Repeating code detector with per-second match ratio and qualification.
// Assumes sec_tick is a one-cycle pulse once per second.
`timescale 1ns/1ps
module lbc_code_det #(
   parameter logic [15:0] PAT = 16'h0018,
   parameter int          LEN = 5
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Timing and stream
   input  wire logic sec_tick,
   lbc_bit_if.dst    s,
   // Result
   output logic      detected
);
   logic [15:0]                     hist_q, hist_d;
   logic [lbc_pkg::BITS_W-1:0]      bits_q, bits_d, miss_q, miss_d;
   logic [lbc_pkg::SECS_W-1:0]      qual_q, qual_d;
   logic                            det_q, det_d, pass, take;

   assign detected = det_q;
   // Framing bits are skipped so inserted codes stay in phase
   assign take = s.bit_en && !s.frame;
   // A second passes when at most one bit in eight mismatched;
   // widened compare so the scaled miss count cannot wrap
   assign pass = (bits_q != '0) &&
      ({miss_q, {lbc_pkg::MISS_SHIFT{1'b0}}} <=
       {{lbc_pkg::MISS_SHIFT{1'b0}}, bits_q});

   // Next history, counters and qualification
   always_comb begin
      hist_d = hist_q;
      bits_d = bits_q;
      miss_d = miss_q;
      qual_d = qual_q;
      det_d  = det_q;
      if (take) begin
         hist_d = {hist_q[14:0], s.bit_val};
         bits_d = bits_q + 1'b1;
         if (!lbc_pkg::rot_match(hist_d, PAT, LEN))
            miss_d = miss_q + 1'b1;
      end
      if (sec_tick) begin
         bits_d = '0;
         miss_d = '0;
         if (!pass) begin
            qual_d = '0;
            det_d  = 1'b0;
         end else if (qual_q != lbc_pkg::SECS_W'(lbc_pkg::QUAL_S)) begin
            qual_d = qual_q + 1'b1;
         end
         if (pass && qual_q == lbc_pkg::SECS_W'(lbc_pkg::QUAL_S - 1))
            det_d = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hist_q <= '0;
         bits_q <= '0;
         miss_q <= '0;
         qual_q <= '0;
         det_q  <= 1'b0;
      end else begin
         hist_q <= hist_d;
         bits_q <= bits_d;
         miss_q <= miss_d;
         qual_q <= qual_d;
         det_q  <= det_d;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_det_qual: assert property ($rose(det_q) |->
      qual_q == lbc_pkg::SECS_W'(lbc_pkg::QUAL_S))
      else $error("code detected before five good seconds");
   a_det_drop: assert property (sec_tick && !pass |=> !det_q)
      else $error("detection held after a failing second");

endmodule : lbc_code_det

// File: lbc_err_burst.sv
// Logic error burst generator: flags a run of bits to be inverted.
// Assumes bit_en marks each transmitted bit toward the network.
`timescale 1ns/1ps
module lbc_err_burst (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Control
   input  wire logic       start,
   input  wire logic [7:0] count,
   input  wire logic       bit_en,
   // Result
   output logic            inject,
   output logic            busy
);
   logic [7:0] left_q, left_d;

   assign busy   = (left_q != '0);
   assign inject = bit_en && busy;

   // Count down one per inverted bit; a new start restarts
   always_comb begin
      left_d = left_q;
      if (start)
         left_d = count;
      else if (inject)
         left_d = left_q - 1'b1;
   end

   // Remaining count register
   always_ff @(posedge mclk) begin
      if (sys_rst) left_q <= '0;
      else         left_q <= left_d;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_burst_len: assert property (start |=> left_q == $past(count))
      else $error("burst length not loaded");

endmodule : lbc_err_burst

// File: lbc_loopback_ctrl.sv
// Loopback command controller: arm, disarm, loop and query handling.
// Assumes line strobes and data arrive from framer logic on mclk.
`timescale 1ns/1ps
module lbc_loopback_ctrl #(
   parameter int SEC_CYCLES = lbc_pkg::SEC_CYCLES
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   // Network side receive stream
   input  wire logic                  net_rx_en,
   input  wire logic                  net_rx_bit,
   input  wire logic                  net_rx_frame,
   // Customer side receive stream
   input  wire logic                  cust_rx_en,
   input  wire logic                  cust_rx_bit,
   input  wire logic                  cust_rx_frame,
   // Facility data link bits
   input  wire logic                  net_fdl_en,
   input  wire logic                  net_fdl_bit,
   input  wire logic                  cust_fdl_en,
   input  wire logic                  cust_fdl_bit,
   // Normal transmit data
   input  wire logic                  net_tx_in,
   input  wire logic                  cust_tx_in,
   // Unit configuration
   input  wire lbc_pkg::lbc_role_type unit_role,
   input  wire logic                  demarc_en,
   // Transmit data
   output logic                       net_tx_bit,
   output logic                       cust_tx_bit,
   // Status
   output logic                       armed,
   output logic                       loop_net,
   output logic                       loop_cust,
   output logic                       ais_active,
   output logic                       err_inject,
   output logic                       line_resync
);
   localparam int TW = $clog2(SEC_CYCLES + 1);
   localparam int NC = lbc_pkg::NUM_CODES;
   localparam int SW = lbc_pkg::SECS_W;

   typedef enum logic [1:0] {
      SEQ_IDLE, SEQ_AIS, SEQ_WAIT, SEQ_HOLD
   } lbc_seq_type;

   logic [TW-1:0]   tick_q, tick_d;
   logic            sec_tick;
   logic [NC-1:0]   det, det_q;
   logic            armed_q, armed_d, lnet_q, lnet_d, lcust_q, lcust_d;
   lbc_seq_type     seq_q, seq_d;
   logic [SW-1:0]   secs_q, secs_d, per_q, per_d;
   logic            resync_q, resync_d, ntx_q, ntx_d, ctx_q, ctx_d;
   logic            arm_any, arm_net, disarm, req_net, req_cust;
   logic            conf_rise, conf_lvl, ldown, qry_rise, qry_lvl;
   logic            burst_start, inject, burst_busy, demarc_hold;

   lbc_bit_if s_if [4] ();

   // Second tick divider
   assign sec_tick = (tick_q == TW'(SEC_CYCLES - 1));
   always_comb begin
      tick_d = sec_tick ? '0 : tick_q + 1'b1;
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) tick_q <= '0;
      else         tick_q <= tick_d;
   end

   // Stream carriers; data link has no framing bit
   assign s_if[0].bit_en  = net_rx_en;
   assign s_if[0].bit_val = net_rx_bit;
   assign s_if[0].frame   = net_rx_frame;
   assign s_if[1].bit_en  = cust_rx_en;
   assign s_if[1].bit_val = cust_rx_bit;
   assign s_if[1].frame   = cust_rx_frame;
   assign s_if[2].bit_en  = net_fdl_en;
   assign s_if[2].bit_val = net_fdl_bit;
   assign s_if[2].frame   = 1'b0;
   assign s_if[3].bit_en  = cust_fdl_en;
   assign s_if[3].bit_val = cust_fdl_bit;
   assign s_if[3].frame   = 1'b0;

   // One detector per code; link words compared bit-reversed
   for (genvar k = 0; k < NC; k++) begin : g_det
      localparam int SRC = int'(lbc_pkg::CODE_SRC[k]);
      localparam logic [15:0] P = (SRC >= 2) ?
         lbc_pkg::rev16(lbc_pkg::CODE_PAT[k]) :
         lbc_pkg::CODE_PAT[k];
      lbc_code_det #(
         .PAT (P),
         .LEN (lbc_pkg::CODE_LEN[k])
      ) u_det (
         .mclk     (mclk),
         .sys_rst  (sys_rst),
         .sec_tick (sec_tick),
         .s        (s_if[SRC]),
         .detected (det[k])
      );
   end

   // Command decode from detection edges and levels
   always_comb begin
      logic rise;
      logic mine;
      rise      = 1'b0;
      mine      = 1'b0;
      arm_any   = 1'b0;
      arm_net   = 1'b0;
      disarm    = 1'b0;
      req_net   = 1'b0;
      req_cust  = 1'b0;
      conf_rise = 1'b0;
      conf_lvl  = 1'b0;
      ldown     = 1'b0;
      qry_rise  = 1'b0;
      qry_lvl   = 1'b0;
      for (int k = 0; k < NC; k++) begin
         rise = det[k] && !det_q[k];
         mine = (lbc_pkg::CODE_ROLE[k] == unit_role);
         case (lbc_pkg::CODE_CMD[k])
            lbc_pkg::CMD_ARM_NET: begin
               arm_any = arm_any | rise;
               arm_net = arm_net | rise;
            end
            lbc_pkg::CMD_ARM_CUST:
               arm_any = arm_any | rise;
            lbc_pkg::CMD_DISARM:
               disarm = disarm | rise;
            lbc_pkg::CMD_LOOP_NET:
               req_net = req_net | (rise && mine);
            lbc_pkg::CMD_LOOP_CUST:
               req_cust = req_cust | (rise && mine);
            lbc_pkg::CMD_ADDR_NET:
               req_net = req_net | (rise && mine && armed_q);
            lbc_pkg::CMD_ADDR_CUST:
               req_cust = req_cust | (rise && mine && armed_q);
            lbc_pkg::CMD_CONFIRM: begin
               conf_rise = conf_rise | (rise && mine && armed_q);
               conf_lvl  = conf_lvl | (det[k] && mine);
            end
            lbc_pkg::CMD_LOOPDOWN:
               ldown = ldown | rise;
            default: begin
               qry_rise = qry_rise | rise;
               qry_lvl  = qry_lvl | det[k];
            end
         endcase
      end
   end

   // Remote unit in demarcation mode keeps its network loop
   assign demarc_hold = demarc_en &&
      (unit_role == lbc_pkg::ROLE_REMOTE);

   // Loop state, confirmation sequence and periodic bursts
   always_comb begin
      armed_d     = armed_q;
      lnet_d      = lnet_q;
      lcust_d     = lcust_q;
      seq_d       = seq_q;
      secs_d      = secs_q;
      per_d       = per_q;
      burst_start = 1'b0;
      if (disarm) begin
         armed_d = 1'b0;
         lnet_d  = 1'b0;
         lcust_d = 1'b0;
         seq_d   = SEQ_IDLE;
      end else begin
         if (arm_any) armed_d = 1'b1;
         if (arm_net && demarc_hold) lnet_d = 1'b1;
         if (req_net) lnet_d = 1'b1;
         if (req_cust) lcust_d = 1'b1;
         // Pattern back while holding resumes bursts, no new AIS
         if (conf_rise && seq_q != SEQ_HOLD) begin
            lnet_d = 1'b1;
            seq_d  = SEQ_AIS;
            secs_d = '0;
         end else begin
            case (seq_q)
               SEQ_AIS: if (sec_tick) begin
                  secs_d = secs_q + 1'b1;
                  if (secs_q == SW'(lbc_pkg::AIS_S - 1)) begin
                     seq_d  = SEQ_WAIT;
                     secs_d = '0;
                  end
               end
               SEQ_WAIT: if (sec_tick) begin
                  secs_d = secs_q + 1'b1;
                  if (secs_q == SW'(lbc_pkg::LOOPED_S - 1)) begin
                     seq_d       = SEQ_HOLD;
                     burst_start = 1'b1;
                     per_d       = '0;
                  end
               end
               default: ;
            endcase
         end
         // Repeat while confirm or query code stays present
         if (qry_rise && lnet_q) begin
            burst_start = 1'b1;
            per_d       = '0;
         end else if (sec_tick && ((seq_q == SEQ_HOLD && conf_lvl) ||
                                   (lnet_q && qry_lvl))) begin
            per_d = per_q + 1'b1;
            if (per_q == SW'(lbc_pkg::REPEAT_S - 1)) begin
               burst_start = 1'b1;
               per_d       = '0;
            end
         end
         if (ldown) begin
            lcust_d = 1'b0;
            if (!demarc_hold) begin
               lnet_d = 1'b0;
               seq_d  = SEQ_IDLE;
            end
         end
      end
   end

   // Release of any loop requests line resynchronisation
   assign resync_d = (lnet_q && !lnet_d) || (lcust_q && !lcust_d);

   // Transmit data paths
   always_comb begin
      ntx_d = ntx_q;
      ctx_d = ctx_q;
      if (net_rx_en) begin
         if (!lnet_q)
            ntx_d = net_tx_in;
         else if (seq_q == SEQ_AIS)
            ntx_d = 1'b1;
         else
            ntx_d = net_rx_bit ^ inject;
      end
      if (cust_rx_en)
         ctx_d = lcust_q ? cust_rx_bit : cust_tx_in;
   end

   lbc_err_burst u_burst (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .start   (burst_start),
      .count   (lbc_pkg::err_count(unit_role)),
      .bit_en  (net_rx_en && lnet_q),
      .inject  (inject),
      .busy    (burst_busy)
   );

   // Control and data registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         det_q    <= '0;
         armed_q  <= 1'b0;
         lnet_q   <= 1'b0;
         lcust_q  <= 1'b0;
         seq_q    <= SEQ_IDLE;
         secs_q   <= '0;
         per_q    <= '0;
         resync_q <= 1'b0;
         ntx_q    <= 1'b0;
         ctx_q    <= 1'b0;
      end else begin
         det_q    <= det;
         armed_q  <= armed_d;
         lnet_q   <= lnet_d;
         lcust_q  <= lcust_d;
         seq_q    <= seq_d;
         secs_q   <= secs_d;
         per_q    <= per_d;
         resync_q <= resync_d;
         ntx_q    <= ntx_d;
         ctx_q    <= ctx_d;
      end
   end

   // Outputs
   assign net_tx_bit  = ntx_q;
   assign cust_tx_bit = ctx_q;
   assign armed       = armed_q;
   assign loop_net    = lnet_q;
   assign loop_cust   = lcust_q;
   assign ais_active  = (seq_q == SEQ_AIS);
   assign err_inject  = inject;
   assign line_resync = resync_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_ais_done;
      seq_q == SEQ_AIS && sec_tick && !disarm && !ldown && !conf_rise &&
      secs_q == SW'(lbc_pkg::AIS_S - 1);
   endsequence
   sequence s_wait_done;
      seq_q == SEQ_WAIT && sec_tick && !disarm && !ldown && !conf_rise &&
      secs_q == SW'(lbc_pkg::LOOPED_S - 1);
   endsequence

   a_disarm_clear: assert property (disarm |=>
      !armed_q && !lnet_q && !lcust_q)
      else $error("disarm did not clear state");
   a_ais_to_data: assert property (s_ais_done |=> seq_q == SEQ_WAIT)
      else $error("AIS phase did not end after two seconds");
   a_first_burst: assert property (s_wait_done |=>
      seq_q == SEQ_HOLD ##1 burst_busy)
      else $error("no burst after looped data phase");
   a_confirm_armed: assert property ($rose(seq_q == SEQ_AIS) |->
      $past(armed_q) && lnet_q)
      else $error("confirmation loop started unarmed");
   a_ldown_keep_arm: assert property (ldown && !disarm && !arm_any |=>
      armed_q == $past(armed_q) && !lcust_q)
      else $error("loop-down changed arming");
   a_demarc_hold: assert property (ldown && demarc_hold && lnet_q &&
      !disarm |=> lnet_q)
      else $error("demarcation unit dropped network loop");
   a_resync_pulse: assert property ($fell(lnet_q) |-> line_resync)
      else $error("no resync on loop release");
   a_query_burst: assert property (qry_rise && lnet_q && !disarm &&
      !ldown |=> ##1 burst_busy)
      else $error("query did not start a burst");

endmodule : lbc_loopback_ctrl

// File: lbc_code_gen.sv
// Test set model: repeats one code on a bit stream, a bit per cycle.
// Assumes the bench clock; drives on the falling edge.
`timescale 1ns/1ps
module lbc_code_gen (
   // Clock
   input  wire logic        mclk,
   // Code choice
   input  wire logic        on,
   input  wire logic        dl,
   input  wire logic [15:0] pat,
   input  wire integer      len,
   // Stream
   output logic             en,
   output logic             bit_val,
   output logic             frame
);
   int idx = 0;
   int cnt = 0;
   initial begin
      en = 1'b0;
      bit_val = 1'b0;
      frame = 1'b0;
   end
   // Code held while on; idle line toggles; framing overwrites
   always @(negedge mclk) begin
      en <= on;
      frame <= on && cnt == 192; // One slot a frame
      cnt <= (cnt == 192) ? 0 : cnt + 1;
      // Data link low bit first, in-band high bit first
      // Index wraps when a shorter code replaces a longer one
      bit_val <= !on ? ~bit_val :
                 dl ? pat[idx % len] : pat[len - 1 - (idx % len)];
      idx <= (idx >= len - 1) ? 0 : idx + 1;
   end
endmodule : lbc_code_gen

// File: testbench.sv
// Bench for the loopback controller: arm, loop, confirm, release.
// Assumes lbc_code_gen as test set; one second is SEC cycles.
`timescale 1ns/1ps
module testbench;
   localparam int SEC = 400;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic on = 1'b0;
   logic dl = 1'b0;
   logic cs = 1'b0;
   logic seen = 1'b0;
   logic [15:0] pat = 16'h0000;
   int len = 5;
   int fails = 0;
   int check_count = 0;
   int errs = 0;
   int cyc = 0;
   logic g_en, g_bit, g_fr;
   logic net_tx_bit, cust_tx_bit, armed, loop_net, loop_cust;
   logic ais_active, err_inject, line_resync;
   logic demarc_en = 1'b0;
   logic net_tx_in = 1'b0;
   logic cust_tx_in = 1'b0;
   lbc_pkg::lbc_role_type unit_role = lbc_pkg::ROLE_CENTRAL;
   // Route the test set onto one of four streams
   wire net_rx_en = g_en & ~dl & ~cs;
   wire cust_rx_en = g_en & ~dl & cs;
   wire net_fdl_en = g_en & dl & ~cs;
   wire cust_fdl_en = g_en & dl & cs;
   wire net_rx_bit = g_bit, cust_rx_bit = g_bit;
   wire net_fdl_bit = g_bit, cust_fdl_bit = g_bit;
   wire net_rx_frame = g_fr, cust_rx_frame = g_fr;

   always #25 mclk = ~mclk;

   lbc_code_gen u_gen (.mclk, .on, .dl, .pat, .len, .en(g_en),
      .bit_val(g_bit), .frame(g_fr));

   lbc_loopback_ctrl #(.SEC_CYCLES(SEC)) u_dut (.mclk, .sys_rst,
      .net_rx_en, .net_rx_bit, .net_rx_frame, .cust_rx_en, .cust_rx_bit,
      .cust_rx_frame, .net_fdl_en, .net_fdl_bit, .cust_fdl_en,
      .cust_fdl_bit, .net_tx_in, .cust_tx_in, .unit_role, .demarc_en,
      .net_tx_bit, .cust_tx_bit, .armed, .loop_net, .loop_cust,
      .ais_active, .err_inject, .line_resync);

   // Error bits, resync pulses and the hang limit
   always @(posedge mclk) begin
      cyc++;
      if (err_inject === 1'b1) errs++;
      if (line_resync === 1'b1) seen = 1'b1;
      if (cyc == 70000) begin
         fails++;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end

   task automatic chk(logic got, logic exp, string m);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic chk_n(int got, int exp, string m);
      check_count++;
      if (got != exp) begin
         fails++;
         $display("mismatch at %0t: %s %0d", $time, m, got);
      end
   endtask : chk_n

   task automatic send(logic [15:0] p, int l, logic d, logic c, int s);
      // Non-blocking so the test set sees a clean change of code
      pat <= p;
      len <= l;
      dl <= d;
      cs <= c;
      on <= 1'b1;
      repeat (s * SEC) @(negedge mclk);
   endtask : send

   task automatic t_short;
      send(16'h0078, 7, 1'b0, 1'b0, 3);
      chk(loop_net, 1'b0, "loop too early");
      send(16'h0078, 7, 1'b0, 1'b0, 4);
      chk(loop_net, 1'b1, "no network loop");
   endtask : t_short

   task automatic t_disarm;
      send(16'h001c, 5, 1'b0, 1'b1, 7);
      chk(loop_net, 1'b0, "loop kept");
      chk(seen, 1'b1, "no resync");
   endtask : t_disarm

   task automatic t_confirm;
      send(16'h0018, 5, 1'b0, 1'b0, 7);
      chk(armed, 1'b1, "not armed");
      send(16'hd3d3, 16, 1'b0, 1'b0, 3);
      for (int i = 0; i < 4 * SEC && loop_net !== 1'b1; i++)
         @(negedge mclk);
      repeat (2) @(negedge mclk);
      chk(ais_active, 1'b1, "no ais");
      chk(net_tx_bit, 1'b1, "ais not ones");
      errs = 0;
      send(16'hd3d3, 16, 1'b0, 1'b0, 10);
      chk_n(errs, 231, "first burst");
      errs = 0;
      send(16'hd3d3, 16, 1'b0, 1'b0, 20);
      chk_n(errs, 231, "repeat burst");
   endtask : t_confirm

   task automatic t_down;
      send(16'h9393, 16, 1'b0, 1'b0, 7);
      chk(loop_net, 1'b0, "loop kept");
      chk(armed, 1'b1, "arm lost");
   endtask : t_down

   task automatic t_fdl;
      send(16'hff24, 16, 1'b1, 1'b0, 7);
      chk(armed, 1'b0, "still armed");
      send(16'hff48, 16, 1'b1, 1'b1, 7);
      chk(armed, 1'b1, "not armed");
      chk(loop_net, 1'b0, "customer arm looped");
   endtask : t_fdl

   task automatic t_remote;
      unit_role = lbc_pkg::ROLE_REMOTE;
      demarc_en = 1'b1;
      send(16'hff48, 16, 1'b1, 1'b0, 7);
      chk(loop_net, 1'b1, "no demarc loop");
      send(16'h9393, 16, 1'b0, 1'b0, 7);
      chk(loop_net, 1'b1, "demarc loop dropped");
      chk(armed, 1'b1, "arm lost on loop-down");
      errs = 0;
      send(16'hd5d5, 16, 1'b0, 1'b0, 7);
      chk_n(errs, 20, "query burst");
      send(16'h007c, 7, 1'b0, 1'b1, 7);
      chk(loop_cust, 1'b1, "no customer loop");
      repeat (8) begin
         @(negedge mclk);
         chk(cust_tx_bit, g_bit, "customer data not looped");
      end
   endtask : t_remote

   task automatic t_addr;
      send(16'hff24, 16, 1'b1, 1'b0, 7);
      chk(loop_cust, 1'b0, "customer loop kept");
      chk(loop_net, 1'b0, "network loop kept");
      demarc_en = 1'b0;
      send(16'hff02, 16, 1'b0, 1'b0, 7);
      chk(loop_net, 1'b0, "unarmed addressed loop");
      send(16'h0018, 5, 1'b0, 1'b0, 7);
      chk(loop_net, 1'b0, "arm looped without demarc");
      send(16'hff02, 16, 1'b0, 1'b0, 7);
      chk(loop_net, 1'b1, "no addressed loop");
   endtask : t_addr

   task automatic end_of_test;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // Reset, then the scenarios in order
   initial begin
      repeat (3) @(negedge mclk);
      sys_rst = 1'b0;
      t_short();
      t_disarm();
      t_confirm();
      t_down();
      t_fdl();
      t_remote();
      t_addr();
      end_of_test();
   end
endmodule : testbench
